/* core/phy_mgmt.sv */
// Management slave with control and status registers of the transceiver
// Function
// - Written control values survive leaving power-down; nothing reloads them then.
// - Auto-negotiation enable resets to the level of its strap pin.
// - Isolate resets to the level of its strap pin.
// - Restart resets to its strap when negotiation is enabled, else to zero.
// - Duplex is ignored under negotiation and otherwise resets from the duplex strap.
// - Collision test acts only while loopback is set.
// - Status shows constant ones for the five abilities and extended capability.
// - Preamble suppression reads zero and frames without full preamble are dropped.
// - Negotiation-complete reads the present completion state.
// - Remote fault sets on partner fault, non CSMA/CD selector or T4-only ability.
// - Remote fault and jabber latch high until the status register is read.
// - Link reads present state but a down event latches it low until read.
// - Jabber is detected only in 10 Mb/s twisted-pair operation.
// - Speed is ignored under negotiation and otherwise resets from its strap.
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // Management serial pins
  input  wire logic                   mdc,
  input  wire logic                   mdio_i,
  output var  logic                   mdio_o,
  output var  logic                   mdio_oe,
  // Strap and address pins
  input  wire phy_mgmt_pkg::straps_t  straps,
  input  wire logic [4:0]             phy_addr,
  // Line-side status from the transceiver core
  input  wire logic                   an_complete,
  input  wire logic                   link_up,
  input  wire logic                   jabber_det,
  input  wire logic                   ten_tp_mode,
  input  wire phy_mgmt_pkg::partner_t partner,
  // Control outputs to the transceiver core
  output var  phy_mgmt_pkg::cfg_t     cfg
);
  import phy_mgmt_pkg::*;

  // ****************************************************************
  // State and pin synchroniser
  // ****************************************************************
  mgmt_t s;
  mgmt_t n;
  pins_t pins_s;
  logic  rise;
  logic  stat_clr;
  logic  jab_set;
  logic  rf_set;

  pin_sync #(
    .W ($bits(pins_t))
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .d_in     ({mdc, mdio_i, straps, phy_addr}),
    .d_out    (pins_s)
  );

  // Control value that the straps select
  function automatic logic [15:0] strap_ctrl(input straps_t p);
    logic [15:0] v;
    v                 = CTL_RESET_VAL;
    v[CTL_AN_ENABLE]  = p.autoneg;
    v[CTL_ISOLATE]    = p.isolate;
    v[CTL_AN_RESTART] = p.autoneg & p.speed_restart;
    v[CTL_DUPLEX]     = p.full_duplex;
    v[CTL_SPEED_100]  = p.speed_restart;
    return v;
  endfunction

  // Status word as seen by a read
  function automatic logic [15:0] status_word(input mgmt_t m, input logic done, input logic up);
    logic [15:0] v;
    v               = ST_FIXED_ONES;
    v[ST_AN_DONE]   = done;
    v[ST_REM_FAULT] = m.rem_fault;
    v[ST_LINK]      = up & ~m.link_low;
    v[ST_JABBER]    = m.jabber;
    return v;
  endfunction

  // ****************************************************************
  // Latched event sources
  // ****************************************************************
  assign rise    = pins_s.mdc & ~s.mdc_prev;
  assign jab_set = jabber_det & ten_tp_mode;
  assign rf_set  = partner.valid & (partner.remote_fault
                 | (partner.selector != SEL_CSMA_CD)
                 | (partner.tech == TECH_T4_ONLY));

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    n          = s;
    stat_clr   = 1'b0;
    n.mdc_prev = pins_s.mdc;
    n.ctrl[CTL_AN_RESTART] = 1'b0;                      // Self-clearing
    // Strap capture after the synchroniser settles
    if (s.boot != 3'h0) begin
      n.boot = s.boot - 3'h1;
      if (s.boot == 3'h1) begin
        n.ctrl = strap_ctrl(pins_s.straps);
      end
    end
    // Serial frame engine, one step per clock rise
    if (rise) begin
      unique case (s.st)
        M_PRE: begin
          if (pins_s.mdio) begin
            n.cnt = (s.cnt == PREAMBLE_ONES) ? s.cnt : s.cnt + 6'h01;
          end else if (s.cnt == PREAMBLE_ONES) begin
            n.st = M_START;
          end else begin
            n.cnt = 6'h00;
          end
        end
        M_START: begin
          n.cnt = 6'h00;
          n.st  = pins_s.mdio ? M_HDR : M_PRE;
        end
        M_HDR: begin
          n.hdr = {s.hdr[10:0], pins_s.mdio};
          n.cnt = s.cnt + 6'h01;
          if (s.cnt == HDR_LAST) begin
            n.cnt = 6'h00;
            n.st  = M_PRE;
            if (n.hdr[9:5] == pins_s.phy_addr
                && (n.hdr[11:10] == OP_READ || n.hdr[11:10] == OP_WRITE)) begin
              n.st = M_TURN;
            end
            if (n.st == M_TURN && n.hdr[11:10] == OP_READ) begin
              n.shreg = 16'h0000;
              if (n.hdr[4:0] == REG_CTRL) begin
                n.shreg = s.ctrl;
              end else if (n.hdr[4:0] == REG_STATUS) begin
                n.shreg  = status_word(s, an_complete, link_up);
                stat_clr = 1'b1;
              end
            end
          end
        end
        M_TURN: begin
          n.cnt = s.cnt + 6'h01;
          if (s.hdr[11:10] == OP_READ) begin
            n.mdio_oe = 1'b1;
            n.mdio_o  = (s.cnt == 6'h00) ? 1'b0 : s.shreg[15];
          end
          if (s.cnt != 6'h00) begin
            n.cnt   = 6'h00;
            n.shreg = {s.shreg[14:0], 1'b0};
            n.st    = (s.hdr[11:10] == OP_READ) ? M_RDATA : M_WDATA;
          end
        end
        M_RDATA: begin
          n.cnt    = s.cnt + 6'h01;
          n.mdio_o = s.shreg[15];
          n.shreg  = {s.shreg[14:0], 1'b0};
          if (s.cnt == DATA_LAST) begin
            n.cnt     = 6'h00;
            n.mdio_oe = 1'b0;
            n.mdio_o  = 1'b0;
            n.st      = M_PRE;
          end
        end
        M_WDATA: begin
          n.cnt   = s.cnt + 6'h01;
          n.shreg = {s.shreg[14:0], pins_s.mdio};
          if (s.cnt == DATA_LAST) begin
            n.cnt = 6'h00;
            n.st  = M_PRE;
            // Only the control register takes writes; power-down exit keeps all bits
            if (s.hdr[4:0] == REG_CTRL) begin
              if (n.shreg[CTL_SOFT_RESET]) begin
                n.ctrl = strap_ctrl(pins_s.straps);
              end else begin
                n.ctrl = n.shreg & CTL_WR_MASK;
              end
            end
          end
        end
      endcase
    end
    // Latches: a new event wins over the read that clears
    n.rem_fault = (s.rem_fault & ~stat_clr) | rf_set;
    n.jabber    = (s.jabber & ~stat_clr) | jab_set;
    n.link_low  = (s.link_low & ~stat_clr) | ~link_up;
    // Control outputs with their qualifiers
    n.cfg.loopback          = n.ctrl[CTL_LOOPBACK];
    n.cfg.col_test_en       = n.ctrl[CTL_COL_TEST] & n.ctrl[CTL_LOOPBACK];
    n.cfg.an_enable         = n.ctrl[CTL_AN_ENABLE];
    n.cfg.an_restart        = n.ctrl[CTL_AN_RESTART];
    n.cfg.force_speed_100   = n.ctrl[CTL_SPEED_100] & ~n.ctrl[CTL_AN_ENABLE];
    n.cfg.force_full_duplex = n.ctrl[CTL_DUPLEX] & ~n.ctrl[CTL_AN_ENABLE];
    n.cfg.power_down        = n.ctrl[CTL_POWER_DOWN];
    n.cfg.isolate           = n.ctrl[CTL_ISOLATE];
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s          <= '0;
      s.st       <= M_PRE;
      s.link_low <= 1'b1;
      s.boot     <= STRAP_SETTLE;
    end else begin
      s <= n;
    end
  end

  assign mdio_o  = s.mdio_o;
  assign mdio_oe = s.mdio_oe;
  assign cfg     = s.cfg;

  // ****************************************************************
  // Assertions and cover points
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  status_fixed_a: assert property (s.st == M_TURN && $past(s.st) == M_HDR
      && s.hdr[4:0] == REG_STATUS && s.hdr[11:10] == OP_READ
      |-> (s.shreg & ST_FIXED_MASK) == ST_FIXED_ONES)
    else $error("status constant bits wrong");
  preamble_count_a: assert property (s.st == M_START && $past(s.st) == M_PRE
      |-> $past(s.cnt) == PREAMBLE_ONES)
    else $error("frame started without full preamble");
  jabber_latch_a: assert property (jab_set
      |=> s.jabber ##1 (s.jabber || $past(stat_clr)))
    else $error("jabber not latched");
  jabber_mode_a: assert property (!s.jabber && !ten_tp_mode |=> !s.jabber)
    else $error("jabber set outside 10 Mb/s twisted pair");
  fault_select_a: assert property (partner.valid && partner.selector != SEL_CSMA_CD
      |=> s.rem_fault)
    else $error("remote fault missed bad selector");
  link_latch_a: assert property (!link_up ##1 link_up && !stat_clr |=> s.link_low)
    else $error("link down not latched");
  read_clear_a: assert property (stat_clr && !jab_set && !rf_set
      |=> !s.jabber && !s.rem_fault)
    else $error("status read did not clear latches");
  col_test_a: assert property (cfg.col_test_en |-> cfg.loopback)
    else $error("collision test without loopback");
  manual_only_a: assert property (cfg.an_enable
      |-> !cfg.force_full_duplex && !cfg.force_speed_100)
    else $error("manual speed or duplex under negotiation");
  strap_load_a: assert property (s.boot == 3'h1
      |=> s.ctrl[CTL_AN_ENABLE] == $past(pins_s.straps.autoneg)
      && s.ctrl[CTL_ISOLATE] == $past(pins_s.straps.isolate)
      && s.ctrl[CTL_AN_RESTART] == $past(pins_s.straps.autoneg & pins_s.straps.speed_restart))
    else $error("strap defaults not loaded");
  restart_pulse_a: assert property (cfg.an_restart |=> !cfg.an_restart)
    else $error("restart not self-clearing");

  status_read_c: cover property (stat_clr ##[1:300] s.st == M_RDATA);
  ctrl_write_c: cover property (s.st == M_WDATA ##[1:300] s.st == M_PRE);
  short_pre_c: cover property (s.st == M_PRE && rise && !pins_s.mdio && s.cnt != 6'h00
      && s.cnt != PREAMBLE_ONES);

endmodule
`default_nettype wire

/* core/phy_mgmt_pkg.sv */
// Shared constants, encodings and carrier types for the transceiver management block
`default_nettype none
package phy_mgmt_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [4:0]  REG_CTRL       = 5'h00;
  localparam logic [4:0]  REG_STATUS     = 5'h01;
  localparam int          CTL_SOFT_RESET = 15;
  localparam int          CTL_LOOPBACK   = 14;
  localparam int          CTL_SPEED_100  = 13;
  localparam int          CTL_AN_ENABLE  = 12;
  localparam int          CTL_POWER_DOWN = 11;
  localparam int          CTL_ISOLATE    = 10;
  localparam int          CTL_AN_RESTART = 9;
  localparam int          CTL_DUPLEX     = 8;
  localparam int          CTL_COL_TEST   = 7;
  localparam logic [15:0] CTL_WR_MASK    = 16'hFF83;  // Bits 6:2 read as zero
  localparam logic [15:0] CTL_RESET_VAL  = 16'h0000;
  localparam int          ST_AN_DONE     = 5;
  localparam int          ST_REM_FAULT   = 4;
  localparam int          ST_LINK        = 2;
  localparam int          ST_JABBER      = 1;
  localparam logic [15:0] ST_FIXED_ONES  = 16'h7809;  // Ability bits 14:11, 3, 0
  localparam logic [15:0] ST_FIXED_MASK  = 16'hFFC9;  // All constant positions

  // ****************************************************************
  // Partner ability codes and frame timing
  // ****************************************************************
  localparam logic [4:0]  SEL_CSMA_CD    = 5'h01;
  localparam logic [4:0]  TECH_T4_ONLY   = 5'h10;
  localparam logic [5:0]  PREAMBLE_ONES  = 6'h20;
  localparam logic [5:0]  HDR_LAST       = 6'h0B;
  localparam logic [5:0]  DATA_LAST      = 6'h0F;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [2:0]  STRAP_SETTLE   = 3'h6;  // Synchroniser needs four edges first

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {M_PRE, M_START, M_HDR, M_TURN, M_RDATA, M_WDATA} mgmt_state_t;

  typedef struct packed {
    logic autoneg;
    logic isolate;
    logic speed_restart;
    logic full_duplex;
  } straps_t;

  typedef struct packed {
    logic       mdc;
    logic       mdio;
    straps_t    straps;
    logic [4:0] phy_addr;
  } pins_t;

  typedef struct packed {
    logic       valid;
    logic       remote_fault;
    logic [4:0] selector;
    logic [4:0] tech;
  } partner_t;

  typedef struct packed {
    logic loopback;
    logic col_test_en;
    logic an_enable;
    logic an_restart;
    logic force_speed_100;
    logic force_full_duplex;
    logic power_down;
    logic isolate;
  } cfg_t;

  typedef struct packed {
    mgmt_state_t st;
    logic [5:0]  cnt;
    logic [11:0] hdr;
    logic [15:0] shreg;
    logic [15:0] ctrl;
    logic        rem_fault;
    logic        jabber;
    logic        link_low;
    logic        mdc_prev;
    logic        mdio_o;
    logic        mdio_oe;
    logic [2:0]  boot;
    cfg_t        cfg;
  } mgmt_t;

endpackage
`default_nettype wire

/* core/pin_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 11
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Pins and filtered levels
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] d_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t s;
  sync_t n;

  // Level moves only once stages two and three agree
  always_comb begin
    n    = s;
    n.s1 = d_in;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.q  = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign d_out = s.q;

endmodule
`default_nettype wire

/* dv/mgmt_station.sv */
// Management station model that runs serial read and write frames
`timescale 1ns/1ns
`default_nettype none
module mgmt_station (
  // Clock
  input  wire logic core_clk,
  // Resolved data wire and station pins
  input  wire logic mdio_w,
  output var  logic mdc,
  output var  logic st_d,
  output var  logic st_en
);
  import phy_mgmt_pkg::*;

  // ********************************
  // Idle pins: clock still, wire released
  // ********************************
  initial begin
    mdc   = 1'b0;
    st_d  = 1'b1;
    st_en = 1'b0;
  end

  // ********************************
  // One frame: ones, start, header, turnaround, 16 data bits
  // ********************************
  task automatic xfer(input int npre, input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rdat);
    logic [31:0] fw;
    int          j;
    fw   = {2'b01, op, pa, ra, 2'b10, wd};
    rdat = 16'h0000;
    for (int i = 0; i < npre + 32; i++) begin
      j = i - npre;
      @(posedge core_clk);
      mdc   <= 1'b0;
      st_d  <= (j < 0) ? 1'b1 : fw[31 - j];
      st_en <= (op == OP_WRITE) || (j < 14);
      repeat (9) @(posedge core_clk);
      // Read bits are long settled half a period after the device changed them
      if (j >= 16) begin
        rdat = {rdat[14:0], mdio_w};
      end
      mdc <= 1'b1;
      repeat (9) @(posedge core_clk);
    end
    @(posedge core_clk);
    mdc   <= 1'b0;
    st_en <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the transceiver management registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import phy_mgmt_pkg::*;
  // ********************************
  // Pins, model state and counters
  // ********************************
  localparam partner_t CALM = '{1'b1, 1'b0, 5'h01, 5'h0F};
  logic                core_clk, reset, mdc, st_d, st_en, mdio_o, mdio_oe;
  logic                an_complete, link_up, jabber_det, ten_tp_mode;
  logic [4:0]          phy_addr;
  logic [15:0]         rd, ctl, w;
  straps_t             straps, s;
  partner_t            partner;
  cfg_t                cfg;
  wire logic           mdio_w;
  int                  num_errors, checks, n_rst, r0;
  bit                  m_rf, m_jab, m_ll;

  // Clock at 100 ns
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Wire has a pull-up when nobody drives it
  assign mdio_w = mdio_oe ? mdio_o : (st_en ? st_d : 1'b1);

  phy_mgmt dut_u (.core_clk(core_clk), .reset(reset), .mdc(mdc), .mdio_i(mdio_w),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .straps(straps), .phy_addr(phy_addr),
    .an_complete(an_complete), .link_up(link_up), .jabber_det(jabber_det),
    .ten_tp_mode(ten_tp_mode), .partner(partner), .cfg(cfg));
  mgmt_station st_u (.core_clk(core_clk), .mdio_w(mdio_w), .mdc(mdc), .st_d(st_d),
    .st_en(st_en));

  // Count restart pulses
  always @(posedge core_clk) begin
    if (cfg.an_restart === 1'b1) n_rst <= n_rst + 1;
  end

  // ********************************
  // Compare, model and bus tasks
  // ********************************
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cfg(input cfg_t got, input cfg_t exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: cfg %b not %b", $time, got, exp);
    end
  endtask

  function automatic cfg_t cfg_exp(input logic [15:0] c);
    return '{c[14], c[14] & c[7], c[12], 1'b0, c[13] & !c[12], c[8] & !c[12], c[11], c[10]};
  endfunction

  task automatic rd_stat(input int npre, input logic [4:0] pa);
    st_u.xfer(npre, OP_READ, pa, REG_STATUS, 16'h0000, rd);
    if (npre >= 32 && pa === phy_addr) begin
      w = {10'h000, an_complete, m_rf, 1'b0, link_up & !m_ll, m_jab, 1'b0};
      cmp_word(rd, w | 16'h7809);
      {m_rf, m_jab, m_ll} = 3'b000;
    end else begin
      cmp_word(rd, 16'hFFFF);
    end
  endtask

  task automatic rd_ctl();
    st_u.xfer(32, OP_READ, phy_addr, REG_CTRL, 16'h0000, rd);
    cmp_word(rd, ctl);
    cmp_cfg(cfg, cfg_exp(ctl));
  endtask

  task automatic wr_ctl(input logic [15:0] v);
    st_u.xfer(32, OP_WRITE, phy_addr, REG_CTRL, v, rd);
    ctl = v & 16'hFD83;
  endtask

  task automatic do_reset(input straps_t sv);
    @(posedge core_clk);
    reset  <= 1'b1;
    straps <= sv;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    repeat (10) @(posedge core_clk);
    {m_rf, m_jab, m_ll} = 3'b001;
  endtask

  // One-cycle line event, then back to a calm line
  task automatic line_event(input int kind, input logic tp);
    @(posedge core_clk);
    ten_tp_mode          <= tp;
    an_complete          <= 1'($urandom);
    jabber_det           <= (kind == 0);
    link_up              <= (kind != 1);
    partner.remote_fault <= (kind == 2);
    partner.selector     <= (kind == 3) ? 5'($urandom) | 5'h02 : 5'h01;
    partner.tech         <= (kind == 4) ? 5'h10 : 5'h0F;
    @(posedge core_clk);
    jabber_det <= 1'b0;
    link_up    <= 1'b1;
    partner    <= CALM;
    repeat (3) @(posedge core_clk);
    m_jab |= (kind == 0) && tp;
    m_ll  |= (kind == 1);
    m_rf  |= (kind >= 2);
  endtask

  task automatic end_test(input string n);
    $display("test %s done, errors %0d", n, num_errors);
  endtask

  task automatic close_out();
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cut a hung run short
  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    $display("unexpected at %0t: run hung", $time);
    close_out();
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    void'($urandom(32'h4746E683));
    reset       = 1'b1;
    straps      = '0;
    phy_addr    = 5'($urandom);
    an_complete = 1'b0;
    link_up     = 1'b1;
    jabber_det  = 1'b0;
    ten_tp_mode = 1'b1;
    partner     = CALM;
    // Strap defaults under both negotiation settings
    for (int i = 0; i < 4; i++) begin
      s  = straps_t'({i[0], 3'($urandom)});
      r0 = n_rst;
      do_reset(s);
      cmp_word(16'(n_rst - r0), {15'h0000, s.autoneg & s.speed_restart});
      ctl = {2'b00, s.speed_restart, s.autoneg, 1'b0, s.isolate, 1'b0, s.full_duplex, 8'h00};
      rd_ctl();
    end
    end_test("straps");
    // Latched flags: set, read once, then clear
    rd_stat(32, phy_addr);
    for (int k = 0; k < 6; k++) begin
      line_event((k < 2) ? 0 : k - 1, k != 1);
      rd_stat(32, phy_addr);
      rd_stat(32, phy_addr);
    end
    end_test("latches");
    // Short preamble, other address and control read leave latches alone
    line_event(0, 1'b1);
    rd_stat(31, phy_addr);
    rd_stat(32, phy_addr ^ 5'h01);
    rd_ctl();
    rd_stat(32, phy_addr);
    end_test("refusals");
    // Power-down exit keeps values; collision test needs loopback
    wr_ctl((16'($urandom) & 16'h3583) | 16'h0880);
    rd_ctl();
    wr_ctl((ctl & 16'hF7FF) | 16'h4000);
    repeat (5) @(posedge core_clk);
    rd_ctl();
    r0 = n_rst;
    wr_ctl(ctl | 16'h0200);
    cmp_word(16'(n_rst - r0), 16'h0001);
    rd_ctl();
    // Soft reset bit reloads the strap defaults of the last reset
    r0 = n_rst;
    wr_ctl(16'h8000);
    cmp_word(16'(n_rst - r0), {15'h0000, s.autoneg & s.speed_restart});
    ctl = {2'b00, s.speed_restart, s.autoneg, 1'b0, s.isolate, 1'b0, s.full_duplex, 8'h00};
    rd_ctl();
    end_test("control");
    close_out();
  end
endmodule
`default_nettype wire
